// ---- design/psmp_port.sv ----
// Programmable synchronous memory port: one access at a time to burst SRAM or a synchronous FIFO.
// Requests arrive on the system clock; the memory side runs on the link clock selected by the
// surrounding clock mux, whose select output this block drives. Words cross by a toggle handshake.
module psmp_port
  import psmp_pkg::*;
#(
  parameter int DATA_W = psmp_pkg::WIDE_DATA_W,
  parameter int BE_W   = DATA_W / 8
) (
  // System domain
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Link domain, the selected external clock
  input  wire logic                        linkClock,
  input  wire logic                        linkRst_n,
  // Per-space control, quasi-static
  input  wire psmp_pkg::psmp_ctrl_t        spaceCtrl [4],
  // Request group
  input  wire logic                        reqValid,
  output logic                             reqReady,
  input  wire psmp_pkg::psmp_req_t         reqInfo,
  input  wire logic [DATA_W-1:0]           reqWdata,
  input  wire logic [BE_W-1:0]             reqBe,
  // Answer group
  output logic                             rspValid,
  output logic [DATA_W-1:0]                rspRdata,
  // Clock choice to the external clock mux
  output logic                             clockSelSecondary,
  // Memory pins
  output logic [3:0]                       chip_select_n,
  output logic [BE_W-1:0]                  byte_enable_n,
  output logic [psmp_pkg::ADDR_W-1:0]      ext_address_bus,
  input  wire logic [DATA_W-1:0]           ext_data_bus_in,
  output logic [DATA_W-1:0]                ext_data_bus_out,
  output logic                             ext_data_bus_oe,
  output logic                             addr_strobe_or_read_enable_n,
  output logic                             sync_output_enable_n,
  output logic                             sync_write_enable_n
);
  import psmp_pkg::*;

  // ---------------- System domain ----------------
  logic              busy_q, busy_d;
  logic              reqTgl_q, reqTgl_d;
  psmp_req_t         hold_q, hold_d;
  logic [DATA_W-1:0] wdHold_q, wdHold_d;
  logic [BE_W-1:0]   beHold_q, beHold_d;
  logic [2:0]        ackSync_q;
  logic              ackSeen_q, ackSeen_d;
  logic              rspValid_d;
  logic [DATA_W-1:0] rspRdata_d;
  logic              selSec_d;
  logic [DATA_W-1:0] rdHold_q;
  logic              ackTgl_q;

  // Acknowledge seen once stages two and three agree
  logic ackStable;
  assign ackStable = (ackSync_q[1] == ackSync_q[2]) ? ackSync_q[2] : ackSeen_q;
  assign reqReady  = !busy_q;

  // Next-state for request capture and answer return
  always_comb begin
    busy_d     = busy_q;
    reqTgl_d   = reqTgl_q;
    hold_d     = hold_q;
    wdHold_d   = wdHold_q;
    beHold_d   = beHold_q;
    ackSeen_d  = ackStable;
    rspValid_d = 1'b0;
    rspRdata_d = rspRdata;
    selSec_d   = clockSelSecondary;
    if (reqValid && !busy_q) begin
      busy_d   = 1'b1;
      reqTgl_d = !reqTgl_q;
      hold_d   = reqInfo;
      wdHold_d = reqWdata;
      beHold_d = reqBe;
      selSec_d = spaceCtrl[reqInfo.space].sync_clock_select;
    end else if (busy_q && (ackStable != ackSeen_q)) begin
      busy_d     = 1'b0;
      rspValid_d = 1'b1;
      rspRdata_d = rdHold_q;
    end
  end

  // Registers of the system domain
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q            <= 1'b0;
      reqTgl_q          <= 1'b0;
      hold_q            <= '0;
      wdHold_q          <= '0;
      beHold_q          <= '0;
      ackSync_q         <= 3'h0;
      ackSeen_q         <= 1'b0;
      rspValid          <= 1'b0;
      rspRdata          <= '0;
      clockSelSecondary <= FLAG_RST;
    end else begin
      busy_q            <= busy_d;
      reqTgl_q          <= reqTgl_d;
      hold_q            <= hold_d;
      wdHold_q          <= wdHold_d;
      beHold_q          <= beHold_d;
      ackSync_q         <= {ackSync_q[1:0], ackTgl_q};
      ackSeen_q         <= ackSeen_d;
      rspValid          <= rspValid_d;
      rspRdata          <= rspRdata_d;
      clockSelSecondary <= selSec_d;
    end
  end

  // ---------------- Link domain ----------------
  // Held request fields are stable while the toggle travels, so they are read directly.
  psmp_state_t       st_q, st_d;
  logic [2:0]        reqSync_q;
  logic              reqSeen_q, reqSeen_d;
  logic              ackTgl_d;
  logic [LAT_W-1:0]  cnt_q, cnt_d;
  logic [DATA_W-1:0] rdHold_d;
  psmp_ctrl_t        cfg;
  logic [3:0]        cs_d;
  logic [BE_W-1:0]   be_d;
  logic [ADDR_W-1:0] ad_d;
  logic [DATA_W-1:0] do_d;
  logic              oe_d, ads_d, soe_d, swe_d;
  logic              reqStable;

  assign reqStable = (reqSync_q[1] == reqSync_q[2]) ? reqSync_q[2] : reqSeen_q;
  assign cfg       = spaceCtrl[hold_q.space];

  // Sequencer: command, latency wait, data, optional deselect
  always_comb begin
    st_d      = st_q;
    reqSeen_d = reqSeen_q;
    ackTgl_d  = ackTgl_q;
    cnt_d     = cnt_q;
    rdHold_d  = rdHold_q;
    cs_d      = 4'hF;
    be_d      = '1;
    ad_d      = ext_address_bus;
    do_d      = ext_data_bus_out;
    oe_d      = 1'b0;
    ads_d     = 1'b1;
    soe_d     = 1'b1;
    swe_d     = 1'b1;
    case (st_q)
      ST_IDLE: begin
        if (reqStable != reqSeen_q) begin
          reqSeen_d = reqStable;
          st_d      = ST_CMD;
          // Command cycle: chip select, address, strobe
          cs_d      = ~(4'h1 << hold_q.space);
          ad_d      = hold_q.addr;
          ads_d     = 1'b0;
          be_d      = ~beHold_q;
          if (hold_q.write) begin
            cnt_d = cfg.write_latency_select;
            swe_d = 1'b0;
            if (cfg.write_latency_select == LAT_RST) begin
              oe_d = 1'b1;
              do_d = wdHold_q;
            end
          end else begin
            cnt_d = cfg.read_latency_select;
            soe_d = 1'b0;
          end
        end
      end
      ST_CMD, ST_WAIT: begin
        // Latency measured from the command edge; zero latency transfers on the next edge
        if (cnt_q == LAT_RST) begin
          if (!hold_q.write) begin
            rdHold_d = ext_data_bus_in;
          end
          ackTgl_d = !ackTgl_q;
          st_d     = cfg.read_enable_mode ? ST_IDLE : ST_DESEL;
        end else begin
          cnt_d = cnt_q - 2'h1;
          st_d  = (cnt_q == 2'h1) ? ST_DATA : ST_WAIT;
        end
        if (!hold_q.write) begin
          soe_d = 1'b0;
          if (cfg.chip_enable_extend) begin
            cs_d = ~(4'h1 << hold_q.space);
          end // else chip select already dropped
        end
        if (hold_q.write && cnt_q == 2'h1) begin
          oe_d = 1'b1;
          do_d = wdHold_q;
          be_d = ~beHold_q;
        end
      end
      ST_DATA: begin
        // Capture on this link edge for reads
        if (!hold_q.write) begin
          rdHold_d = ext_data_bus_in;
        end
        ackTgl_d = !ackTgl_q;
        st_d     = cfg.read_enable_mode ? ST_IDLE : ST_DESEL;
      end
      ST_DESEL: begin
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Registers of the link domain; pins change only on link edges
  always_ff @(posedge linkClock or negedge linkRst_n) begin
    if (!linkRst_n) begin
      st_q                         <= ST_IDLE;
      reqSync_q                    <= 3'h0;
      reqSeen_q                    <= 1'b0;
      ackTgl_q                     <= 1'b0;
      cnt_q                        <= LAT_RST;
      rdHold_q                     <= '0;
      chip_select_n                <= 4'hF;
      byte_enable_n                <= '1;
      ext_address_bus              <= '0;
      ext_data_bus_out             <= '0;
      ext_data_bus_oe              <= 1'b0;
      addr_strobe_or_read_enable_n <= 1'b1;
      sync_output_enable_n         <= 1'b1;
      sync_write_enable_n          <= 1'b1;
    end else begin
      st_q                         <= st_d;
      reqSync_q                    <= {reqSync_q[1:0], reqTgl_q};
      reqSeen_q                    <= reqSeen_d;
      ackTgl_q                     <= ackTgl_d;
      cnt_q                        <= cnt_d;
      rdHold_q                     <= rdHold_d;
      chip_select_n                <= cs_d;
      byte_enable_n                <= be_d;
      ext_address_bus              <= ad_d;
      ext_data_bus_out             <= do_d;
      ext_data_bus_oe              <= oe_d;
      addr_strobe_or_read_enable_n <= ads_d;
      sync_output_enable_n         <= soe_d;
      sync_write_enable_n          <= swe_d;
    end
  end

  // Instance widths: wide 64/8, narrow 16/2 via DATA_W parameter.
endmodule : psmp_port

// ---- design/psmp_pkg.sv ----
// Package for the programmable synchronous memory port: constants, field layouts and carrier types.
// Assumes a single system clock domain plus one link domain on the selected external clock.
// Overview of operation
// - Read latency per space is selectable as zero, one, two or three link cycles.
// - Write latency per space is selectable as zero, one, two or three link cycles.
// - With chip-enable extend at 0 the chip select drops once the last command is issued.
// - With chip-enable extend at 1 the chip select stays active while the output enable is active.
// - With read-enable mode at 0 the shared strobe is an address strobe and deselect cycles are inserted.
// - With read-enable mode at 1 the shared strobe is a FIFO read enable with no deselect cycles.
// - The link runs from one of two external clock outputs chosen per space.
// - The three shared control pins act as address strobe or read enable, output enable and write enable.
// - Read data is captured on the rising edge of the selected external clock.
// - All memory-side outputs change only on rising edges of the selected external clock.
// - The wide port has 64 data bits and eight byte enables, the narrow one 16 bits and two.
package psmp_pkg;

  // Port widths for the two instances
  localparam int WIDE_DATA_W   = 64;
  localparam int NARROW_DATA_W = 16;
  localparam int ADDR_W        = 20;
  localparam int SPACE_W       = 2;
  localparam int LAT_W         = 2;

  // Reset values of the control register
  localparam logic [1:0] LAT_RST   = 2'h0;
  localparam logic       FLAG_RST  = 1'h0;
  localparam logic [2:0] SYNC_RST  = 3'h0;

  // Per-space secondary control
  typedef struct packed {
    logic [LAT_W-1:0] read_latency_select;
    logic [LAT_W-1:0] write_latency_select;
    logic             chip_enable_extend;
    logic             read_enable_mode;
    logic             sync_clock_select;
  } psmp_ctrl_t;

  // One access request crossing into the link domain
  typedef struct packed {
    logic              write;
    logic [SPACE_W-1:0] space;
    logic [ADDR_W-1:0]  addr;
  } psmp_req_t;

  // Link-side sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WAIT, ST_DATA, ST_DESEL} psmp_state_t;

endpackage : psmp_pkg

// ---- test/psmp_checker.sv ----
// Concurrent checks on the memory-side pins of the synchronous port.
// Assumes all four spaces carry one setting, so space 0 stands for the active one.
module psmp_checker
  import psmp_pkg::*;
(
  // Link domain
  input wire logic                 linkClock,
  input wire logic                 linkRst_n,
  input wire psmp_pkg::psmp_ctrl_t spaceCtrl [4],
  // Memory pins
  input wire logic [3:0]           chip_select_n,
  input wire logic                 ext_data_bus_oe,
  input wire logic                 addr_strobe_or_read_enable_n,
  input wire logic                 sync_output_enable_n,
  input wire logic                 sync_write_enable_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge linkClock); endclocking
  default disable iff (!linkRst_n);
  // Any space selected
  logic csAny;
  assign csAny = chip_select_n != 4'hF;

  cs_onehot_a : assert property ($onehot0(~chip_select_n))
    else $error("several chip selects low");
  write_cmd_a : assert property (!sync_write_enable_n |-> csAny && !addr_strobe_or_read_enable_n)
    else $error("write enable outside a command");
  oe_excl_a : assert property (!sync_output_enable_n |-> sync_write_enable_n)
    else $error("output and write enable together");
  cs_drop_a : assert property (csAny && !spaceCtrl[0].chip_enable_extend |-> !addr_strobe_or_read_enable_n)
    else $error("chip select held past command");
  cs_hold_a : assert property (!sync_output_enable_n && spaceCtrl[0].chip_enable_extend |-> csAny)
    else $error("chip select dropped while output enabled");
  desel_gap_a : assert property (!addr_strobe_or_read_enable_n && !spaceCtrl[0].read_enable_mode |=>
    addr_strobe_or_read_enable_n)
    else $error("no deselect after address strobe");
  wlat_zero_a : assert property (!sync_write_enable_n && spaceCtrl[0].write_latency_select == 2'h0
    |-> ext_data_bus_oe)
    else $error("write data late at latency zero");
  wlat_three_a : assert property ($fell(sync_write_enable_n) && spaceCtrl[0].write_latency_select == 2'h3
    |-> !ext_data_bus_oe [*3] ##1 ext_data_bus_oe)
    else $error("write data off latency three");
endmodule : psmp_checker

bind psmp_port psmp_checker chk (.linkClock(linkClock), .linkRst_n(linkRst_n), .spaceCtrl(spaceCtrl),
  .chip_select_n(chip_select_n), .ext_data_bus_oe(ext_data_bus_oe),
  .addr_strobe_or_read_enable_n(addr_strobe_or_read_enable_n),
  .sync_output_enable_n(sync_output_enable_n), .sync_write_enable_n(sync_write_enable_n));

// ---- test/psmp_sram_model.sv ----
// One-word synchronous SRAM or FIFO standing at the far side of the port.
// Assumes the bench resolves the shared data wire from the port's data output enable alone.
module psmp_sram_model
  import psmp_pkg::*;
(
  // Link clock and latency in use
  input wire logic        linkClock,
  input wire logic [1:0]  rdLat,
  // Pins from the port
  input wire logic [3:0]  chip_select_n,
  input wire logic [7:0]  byte_enable_n,
  input wire logic [63:0] ext_data_bus_out,
  input wire logic        ext_data_bus_oe,
  input wire logic        addr_strobe_or_read_enable_n,
  input wire logic        sync_output_enable_n,
  input wire logic        sync_write_enable_n,
  // Returned word and last space seen
  output logic [63:0]     dataOut,
  output logic [3:0]      csSeen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] mem = 64'h0;
  logic [1:0]  cnt = 2'h0;
  logic        rdCmd;
  assign rdCmd = chip_select_n != 4'hF && !addr_strobe_or_read_enable_n && !sync_output_enable_n;
  // Word valid only up to its capture edge; inverted otherwise so a wrong edge shows
  assign dataOut = (cnt == 2'h1 || (rdCmd && rdLat == 2'h0)) ? mem : ~mem;
  // Latency count and masked write
  always @(posedge linkClock) begin
    if (cnt != 2'h0)
      cnt <= cnt - 2'h1;
    if (rdCmd)
      cnt <= rdLat;
    if (chip_select_n != 4'hF)
      csSeen <= chip_select_n;
    if (ext_data_bus_oe)
      for (int i = 0; i < 8; i++)
        if (!byte_enable_n[i])
          mem[i*8 +: 8] <= ext_data_bus_out[i*8 +: 8];
  end
endmodule : psmp_sram_model

// ---- test/programmable_sync_memory_port_test.sv ----
// Self-checking bench for the wide synchronous memory port with a one-word memory model.
// Assumes a free-running link clock; every access waits for its answer before the next.
module programmable_sync_memory_port_test;
  import psmp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0, rst_n = 1'b0, linkClock = 1'b0, linkRst_n = 1'b0, reqValid = 1'b0;
  psmp_ctrl_t  spaceCtrl [4];
  psmp_req_t   reqInfo = '0;
  logic [63:0] reqWdata = 64'h0, rspRdata, busIn, modelOut, dataOut, rdata;
  logic [7:0]  reqBe = 8'hFF, byteEn_n;
  logic [3:0]  cs_n, csSeen;
  logic [19:0] addrBus;
  logic        reqReady, rspValid, clockSelSecondary, oe, ads_n, soe_n, swe_n;
  int          n_fail = 0, n_compared = 0;
  // Shared data wire
  assign busIn = oe ? dataOut : modelOut;

  psmp_port #(.DATA_W(64)) dut (.clock(clock), .rst_n(rst_n), .linkClock(linkClock), .linkRst_n(linkRst_n),
    .spaceCtrl(spaceCtrl), .reqValid(reqValid), .reqReady(reqReady), .reqInfo(reqInfo), .reqWdata(reqWdata),
    .reqBe(reqBe), .rspValid(rspValid), .rspRdata(rspRdata), .clockSelSecondary(clockSelSecondary),
    .chip_select_n(cs_n), .byte_enable_n(byteEn_n), .ext_address_bus(addrBus), .ext_data_bus_in(busIn),
    .ext_data_bus_out(dataOut), .ext_data_bus_oe(oe), .addr_strobe_or_read_enable_n(ads_n),
    .sync_output_enable_n(soe_n), .sync_write_enable_n(swe_n));
  psmp_sram_model mem (.linkClock(linkClock), .rdLat(spaceCtrl[0].read_latency_select), .chip_select_n(cs_n),
    .byte_enable_n(byteEn_n), .ext_data_bus_out(dataOut), .ext_data_bus_oe(oe),
    .addr_strobe_or_read_enable_n(ads_n), .sync_output_enable_n(soe_n), .sync_write_enable_n(swe_n),
    .dataOut(modelOut), .csSeen(csSeen));

  // Clocks, link offset so phases never line up
  initial forever #2.5 clock = ~clock;
  initial begin
    #37;
    forever #80 linkClock = ~linkClock;
  end

  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task finish_test;
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  // Same setting in every space; only changed while idle
  task set_ctrl(input logic [1:0] rl, input logic [1:0] wl, input logic ext, input logic md);
    for (int s = 0; s < 4; s++)
      spaceCtrl[s] = '{rl, wl, ext, md, 1'b0};
  endtask : set_ctrl

  // One request, then a bounded wait for its answer
  task access(input logic wr, input logic [1:0] sp, input logic [63:0] wd, input logic [7:0] be);
    int n;
    @(negedge clock);
    reqValid = 1'b1;
    reqInfo = {wr, sp, 20'h0_0abc};
    reqWdata = wd;
    reqBe = be;
    @(negedge clock);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    if (n == 1000) begin
      n_fail++;
      finish_test();
    end
    rdata = rspRdata;
  endtask : access

  task sc_latency;
    for (int l = 0; l < 4; l++) begin
      set_ctrl(l[1:0], l[1:0], 1'b0, 1'b0);
      access(1'b1, 2'h0, 64'h0123_4567_89ab_cde0 + 64'(l), 8'hFF);
      access(1'b0, 2'h0, 64'h0, 8'hFF);
      check("latency_word", rdata, 64'h0123_4567_89ab_cde0 + 64'(l));
    end
    // Low half only, at the longest latency
    access(1'b1, 2'h0, 64'hFFFF_FFFF_FFFF_FFFF, 8'h0F);
    access(1'b0, 2'h0, 64'h0, 8'hFF);
    check("byte_mask", rdata, 64'h0123_4567_FFFF_FFFF);
  endtask : sc_latency

  task sc_fifo;
    set_ctrl(2'h2, 2'h1, 1'b1, 1'b1);
    access(1'b1, 2'h3, 64'hA5A5_5A5A_C3C3_3C3C, 8'hFF);
    access(1'b0, 2'h3, 64'h0, 8'hFF);
    check("fifo_word", rdata, 64'hA5A5_5A5A_C3C3_3C3C);
    check("fifo_space", csSeen, 4'h7);
    check("fifo_addr", addrBus, 20'h0_0abc);
  endtask : sc_fifo

  task sc_clock_sel;
    set_ctrl(2'h1, 2'h3, 1'b0, 1'b0);
    spaceCtrl[2].sync_clock_select = 1'b1;
    access(1'b0, 2'h2, 64'h0, 8'hFF);
    check("clock_sel_2", clockSelSecondary, 1'b1);
    check("space_2", csSeen, 4'hB);
    access(1'b0, 2'h1, 64'h0, 8'hFF);
    check("clock_sel_1", clockSelSecondary, 1'b0);
    check("space_1", csSeen, 4'hD);
  endtask : sc_clock_sel

  // Reset both domains, check idle pins, run the scenarios
  initial begin
    set_ctrl(2'h0, 2'h0, 1'b0, 1'b0);
    repeat (16) @(negedge clock);
    repeat (2) @(posedge linkClock);
    @(negedge clock);
    rst_n = 1'b1;
    linkRst_n = 1'b1;
    check("idle_cs", cs_n, 4'hF);
    check("idle_ready", reqReady, 1'b1);
    check("idle_oe", oe, 1'b0);
    sc_latency();
    sc_fifo();
    sc_clock_sel();
    finish_test();
  end
endmodule : programmable_sync_memory_port_test
